// ### hdl/can_msg_defs.svh
`ifndef CAN_MSG_DEFS_SVH
`define CAN_MSG_DEFS_SVH

// ----------------------------------------
// register word addresses
// ----------------------------------------
`define ADDR_GCTRL   6'h00
`define ADDR_GSTAT   6'h01
`define ADDR_MA_LO   6'h02
`define ADDR_MA_HI   6'h03
`define ADDR_DP_PTR  6'h04
`define ADDR_DP_BUF  6'h05
`define ADDR_BTIME   6'h06
`define ADDR_NEWDAT  6'h07
`define ADDR_SRC     6'h08
`define ADDR_CCTL0   6'h10

// ----------------------------------------
// center control bits
// ----------------------------------------
`define CC_DIR       0
`define CC_HOLD      1
`define CC_UPD       2
`define CC_RDY       3
`define CC_TRQ       4
`define CC_INTEN     5
`define CC_EXT       6
`define CC_MASKED    7
`define CC_AUTORMT   8
`define CC_DLC_LO    9
`define CC_DLC_HI    12

// ----------------------------------------
// memory layout, sizes and reset values
// ----------------------------------------
`define MEM_W_IDHI   3'h0
`define MEM_W_IDLO   3'h1
`define MEM_W_DATA0  3'h2
`define MEM_W_DMASK  3'h2
`define NUM_CENTERS  15
`define LAST_SCAN    4'hE
`define CATCH_ALL    4'hF
`define DATA_BEATS   2'h3
`define REPLY_BEATS  3'h6
`define FIFO_DEPTH   32
`define RST_BTIME    16'h0000
`define RST_CCTL     16'h0000

`endif

// ### hdl/can_msg_pkg.sv
package can_msg_pkg;

    typedef struct packed {
        logic        ext;
        logic        rtr;
        logic [28:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } can_frame_t;

    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        IDLE,
        SCAN,
        STORE,
        REPLY
    } mc_state_t;

endpackage

// ### hdl/tx_word_fifo.sv
`timescale 1ns/100ps

module tx_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // fill side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // drain side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             outValid_q;
    logic [WIDTH-1:0] outData_q;

    wire full   = (count_q == (AW+1)'(DEPTH));
    wire empty  = (count_q == '0);
    wire push   = inValid && !full;
    // output stage is a register so the drain sees no memory path
    wire load   = !empty && (!outValid_q || outReady);

    assign inReady  = !full;
    assign outValid = outValid_q;
    assign outData  = outData_q;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wrPtr_q    <= '0;
            rdPtr_q    <= '0;
            count_q    <= '0;
            outValid_q <= 1'b0;
            outData_q  <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + AW'(1);
            end
            if (load) begin
                rdPtr_q   <= rdPtr_q + AW'(1);
                outData_q <= mem[rdPtr_q];
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(load);
            if (load) begin
                outValid_q <= 1'b1;
            end else if (outReady) begin
                outValid_q <= 1'b0;
            end
        end
    end
endmodule

// ### hdl/can_message_center.sv
`timescale 1ns/100ps
`include "can_msg_defs.svh"

module can_message_center #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // processor register port
    input  wire can_msg_pkg::reg_req_t  regReq,
    output logic [15:0]                 rdData,
    // received frames from the CAN engine
    input  wire logic                   rxValid,
    input  wire can_msg_pkg::can_frame_t rxFrame,
    output logic                        rxBusy,
    // reply words toward the CAN engine
    output logic                        txValid,
    output logic [15:0]                 txWord,
    input  wire logic                   txReady,
    // engine status and setup
    input  wire logic [7:0]             errorInfo,
    input  wire logic                   busOff,
    output logic [15:0]                 bitTiming,
    output logic                        canEnable,
    output logic                        centerIrq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [15:0]             mem [128];
    logic [15:0]             cctl_q [16];
    logic [6:0]              dpPtr_q;
    logic [7:0]              maLo_q;
    logic [7:0]              maHi_q;
    logic [15:0]             bTime_q;
    logic                    enable_q;
    logic [15:1]             newData_q;
    logic [3:0]              src_q;
    logic                    overrun_q;
    logic [15:0]             rdData_q;
    logic                    irq_q;
    can_msg_pkg::mc_state_t  state_q;
    can_msg_pkg::can_frame_t frame_q;
    logic [3:0]              idx_q;
    logic [2:0]              beat_q;
    logic                    busy_q;

    // ----------------------------------------
    // decoding
    // ----------------------------------------
    function automatic logic txArmed(input logic [15:0] c);
        return c[`CC_DIR] && !c[`CC_HOLD] && c[`CC_UPD] && c[`CC_RDY] && c[`CC_TRQ];
    endfunction

    function automatic logic [6:0] wordAddr(input logic [3:0] n, input logic [2:0] w);
        return {n, w};
    endfunction

    wire        wrStb    = regReq.wr;
    wire        rdStb    = regReq.rd;
    wire [5:0]  addr     = regReq.addr;
    wire        cctlSel  = (addr[5:4] == 2'b01) && (addr[3:0] != 4'h0);
    wire [3:0]  cctlIdx  = addr[3:0];
    wire        bufWr    = wrStb && (addr == `ADDR_DP_BUF);

    wire [15:0] ctl      = cctl_q[idx_q];
    wire [28:0] idMask   = {mem[wordAddr(4'h0, `MEM_W_IDHI)][12:0], mem[wordAddr(4'h0, `MEM_W_IDLO)]};
    wire [15:0] dataMask = mem[wordAddr(4'h0, `MEM_W_DMASK)];
    wire [15:0] idHiWord = mem[wordAddr(idx_q, `MEM_W_IDHI)];
    wire [28:0] centerId = {idHiWord[12:0], mem[wordAddr(idx_q, `MEM_W_IDLO)]};
    // unmasked centers compare every ID bit of their format (11 standard, 29 extended); masked ones skip global mask bits
    wire [28:0] useMask  = ctl[`CC_MASKED] ? idMask : 29'h0;
    wire [28:0] fmtMask  = ctl[`CC_EXT] ? 29'h1FFFFFFF : 29'h000007FF;
    wire        idHit    = (((frame_q.id ^ centerId) & ~useMask & fmtMask) == 29'h0)
                           && (frame_q.ext == ctl[`CC_EXT]);
    wire [15:0] mediaIn  = frame_q.data[63:48];
    wire        mediaHit = (((mediaIn ^ {maLo_q, maHi_q}) & ~(ctl[`CC_MASKED] ? dataMask : 16'h0))
                           == 16'h0);
    wire        rxHit    = !frame_q.rtr && !ctl[`CC_DIR] && ctl[`CC_RDY] && idHit && mediaHit;
    wire        rmtHit   = frame_q.rtr && txArmed(ctl) && ctl[`CC_AUTORMT] && idHit;
    wire        lastScan = (idx_q == `LAST_SCAN);

    // ----------------------------------------
    // reply words into the FIFO
    // ----------------------------------------
    logic [15:0] replyWord;
    wire         fifoReady;
    wire         replyPush = (state_q == can_msg_pkg::REPLY);
    wire         fifoValid;
    wire [15:0]  fifoData;

    always_comb begin
        unique case (beat_q)
            3'h0:    replyWord = {ctl[`CC_EXT], 2'b00, idHiWord[12:0]};
            3'h1:    replyWord = mem[wordAddr(idx_q, `MEM_W_IDLO)];
            3'h2:    replyWord = {12'h000, ctl[`CC_DLC_HI:`CC_DLC_LO]};
            default: replyWord = mem[wordAddr(idx_q, 3'(beat_q - 3'h1))];
        endcase
    end

    tx_word_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) replyFifo (
        .clock    (clock),
        .rst      (rst),
        .inValid  (replyPush),
        .inData   (replyWord),
        .inReady  (fifoReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (txReady)
    );

    assign txValid = fifoValid;
    assign txWord  = fifoData;

    // ----------------------------------------
    // acceptance sequencer
    // ----------------------------------------
    wire startRx   = rxValid && (state_q == can_msg_pkg::IDLE) && enable_q;
    wire storeDone = (state_q == can_msg_pkg::STORE) && (beat_q[1:0] == `DATA_BEATS);
    wire replyDone = replyPush && fifoReady && (beat_q == `REPLY_BEATS);
    wire scanDrop  = (state_q == can_msg_pkg::SCAN) && !rxHit && !rmtHit && lastScan && frame_q.rtr;
    // engine write port: data words land while in STORE
    wire         engWr   = (state_q == can_msg_pkg::STORE);
    wire [6:0]   engAddr = wordAddr(idx_q, 3'(`MEM_W_DATA0 + beat_q));
    logic [15:0] engData;

    always_comb begin
        unique case (beat_q[1:0])
            2'h0: engData = frame_q.data[63:48];
            2'h1: engData = frame_q.data[47:32];
            2'h2: engData = frame_q.data[31:16];
            2'h3: engData = frame_q.data[15:0];
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= can_msg_pkg::IDLE;
            idx_q   <= 4'h1;
            beat_q  <= 3'h0;
            frame_q <= '0;
            busy_q  <= 1'b0;
        end else begin
            busy_q <= startRx || (busy_q && !(storeDone || replyDone || scanDrop));
            unique case (state_q)
                can_msg_pkg::IDLE: begin
                    if (startRx) begin
                        frame_q <= rxFrame;
                        idx_q   <= 4'h1;
                        state_q <= can_msg_pkg::SCAN;
                    end
                end
                can_msg_pkg::SCAN: begin
                    beat_q <= 3'h0;
                    if (rxHit) begin
                        state_q <= can_msg_pkg::STORE;
                    end else if (rmtHit) begin
                        state_q <= can_msg_pkg::REPLY;
                    end else if (!lastScan) begin
                        idx_q <= idx_q + 4'h1;
                    end else if (frame_q.rtr) begin
                        state_q <= can_msg_pkg::IDLE;
                    end else begin
                        idx_q   <= `CATCH_ALL;
                        state_q <= can_msg_pkg::STORE;
                    end
                end
                can_msg_pkg::STORE: begin
                    beat_q <= beat_q + 3'h1;
                    if (storeDone) begin
                        state_q <= can_msg_pkg::IDLE;
                    end
                end
                can_msg_pkg::REPLY: begin
                    // a full FIFO holds the sequencer here until the engine drains
                    if (fifoReady) begin
                        beat_q <= beat_q + 3'h1;
                    end
                    if (replyDone) begin
                        state_q <= can_msg_pkg::IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // shared memory, two writers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (bufWr) begin
            mem[dpPtr_q] <= regReq.wdata;
        end
        if (engWr) begin
            mem[engAddr] <= engData;
        end
    end

    // ----------------------------------------
    // center control registers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 1; g <= `NUM_CENTERS; g++) begin : gCenter
            wire hit   = storeDone && (idx_q == 4'(g));
            wire swWr  = wrStb && cctlSel && (cctlIdx == 4'(g));
            logic [15:0] wv;
            always_comb begin
                wv = regReq.wdata;
                if (g == `NUM_CENTERS) begin
                    wv[`CC_DIR] = 1'b0;
                end
            end
            always_ff @(posedge clock) begin
                if (rst) begin
                    cctl_q[g] <= `RST_CCTL;
                end else if (hit) begin
                    cctl_q[g][`CC_UPD]                <= 1'b1;
                    cctl_q[g][`CC_DLC_HI:`CC_DLC_LO] <= frame_q.dlc;
                end else if (swWr) begin
                    cctl_q[g] <= wv;
                end
            end
            // hardware set beats a same-cycle write-one clear
            always_ff @(posedge clock) begin
                if (rst) begin
                    newData_q[g] <= 1'b0;
                end else if (hit) begin
                    newData_q[g] <= 1'b1;
                end else if (wrStb && (addr == `ADDR_NEWDAT) && regReq.wdata[g]) begin
                    newData_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (rst) begin
            cctl_q[0] <= `RST_CCTL;
        end
    end

    // ----------------------------------------
    // global registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            dpPtr_q  <= '0;
            maLo_q   <= '0;
            maHi_q   <= '0;
            bTime_q  <= `RST_BTIME;
            enable_q <= 1'b0;
        end else if (wrStb) begin
            unique case (addr)
                `ADDR_DP_PTR: dpPtr_q  <= regReq.wdata[6:0];
                `ADDR_MA_LO:  maLo_q   <= regReq.wdata[7:0];
                `ADDR_MA_HI:  maHi_q   <= regReq.wdata[7:0];
                `ADDR_BTIME:  bTime_q  <= regReq.wdata;
                `ADDR_GCTRL:  enable_q <= regReq.wdata[0];
                default:      ;
            endcase
        end
    end

    wire overrunClr = wrStb && (addr == `ADDR_GSTAT) && regReq.wdata[15];

    always_ff @(posedge clock) begin
        if (rst) begin
            src_q     <= 4'h0;
            overrun_q <= 1'b0;
        end else begin
            if (storeDone || replyDone) begin
                src_q <= idx_q;
            end
            if (rxValid && state_q != can_msg_pkg::IDLE) begin
                overrun_q <= 1'b1;
            end else if (overrunClr) begin
                overrun_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // read path, data one cycle after strobe
    // ----------------------------------------
    wire [15:0] gstat   = {overrun_q, 6'h00, busOff, errorInfo};
    wire [15:0] newWord = {newData_q, 1'b0};
    wire [15:0] rdMux   =
        (addr == `ADDR_GCTRL)  ? {15'h0000, enable_q} :
        (addr == `ADDR_GSTAT)  ? gstat :
        (addr == `ADDR_MA_LO)  ? {8'h00, maLo_q} :
        (addr == `ADDR_MA_HI)  ? {8'h00, maHi_q} :
        (addr == `ADDR_DP_PTR) ? {9'h000, dpPtr_q} :
        (addr == `ADDR_DP_BUF) ? mem[dpPtr_q] :
        (addr == `ADDR_BTIME)  ? bTime_q :
        (addr == `ADDR_NEWDAT) ? newWord :
        (addr == `ADDR_SRC)    ? {12'h000, src_q} :
        cctlSel                ? cctl_q[cctlIdx] :
                                 16'h0000;

    // per-center interrupt enables gate the new-data flags
    logic [15:1] irqTerms;
    always_comb begin
        for (int i = 1; i <= `NUM_CENTERS; i++) begin
            irqTerms[i] = newData_q[i] && cctl_q[i][`CC_INTEN];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdData_q <= 16'h0000;
            irq_q    <= 1'b0;
        end else begin
            rdData_q <= rdStb ? rdMux : 16'h0000;
            irq_q    <= |irqTerms;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdData    = rdData_q;
    assign rxBusy    = busy_q;
    assign bitTiming = bTime_q;
    assign canEnable = enable_q;
    assign centerIrq = irq_q;
endmodule

// ### verification/can_mc_monitor.sv
`timescale 1ns/100ps
`include "can_msg_defs.svh"

module can_mc_monitor #(
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic                    clock,
    input wire logic                    rst,
    // register port
    input wire can_msg_pkg::reg_req_t   regReq,
    input wire logic [15:0]             rdData,
    // engine side
    input wire logic                    rxValid,
    input wire can_msg_pkg::can_frame_t rxFrame,
    input wire logic                    rxBusy,
    input wire logic                    txValid,
    input wire logic [15:0]             txWord,
    input wire logic                    txReady,
    // status and setup
    input wire logic [7:0]              errorInfo,
    input wire logic                    busOff,
    input wire logic [15:0]             bitTiming,
    input wire logic                    canEnable,
    input wire logic                    centerIrq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    rd_idle_a: assert property (
        !$past(regReq.rd) |-> rdData == 16'h0000) else $error("read data outside answer cycle");
    stat_read_a: assert property (
        regReq.rd && regReq.addr == `ADDR_GSTAT |=> rdData[8:0] == {$past(busOff), $past(errorInfo)})
        else $error("status read wrong");
    hole_read_a: assert property (
        regReq.rd && regReq.addr == 6'h0A |=> rdData == 16'h0000) else $error("unmapped read not zero");
    timing_write_a: assert property (
        regReq.wr && regReq.addr == `ADDR_BTIME |=> bitTiming == $past(regReq.wdata))
        else $error("bit timing not updated");
    frame_take_a: assert property (
        rxValid && !rxBusy && canEnable |=> rxBusy) else $error("frame not taken");
    frame_drop_a: assert property (
        rxValid && !rxBusy && !canEnable |=> !rxBusy) else $error("frame taken while disabled");
    busy_bound_a: assert property (
        $rose(rxBusy) |-> ##[1:1000] !rxBusy) else $error("sequencer stuck busy");
    tx_hold_a: assert property (
        txValid && !txReady |=> txValid && $stable(txWord)) else $error("reply word not held");

    cover property (rxValid && rxBusy);
    cover property (txValid && !txReady);
    cover property ($fell(rxBusy) && canEnable);
endmodule

bind can_message_center can_mc_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon_u (
    .clock(clock), .rst(rst), .regReq(regReq), .rdData(rdData), .rxValid(rxValid), .rxFrame(rxFrame),
    .rxBusy(rxBusy), .txValid(txValid), .txWord(txWord), .txReady(txReady), .errorInfo(errorInfo),
    .busOff(busOff), .bitTiming(bitTiming), .canEnable(canEnable), .centerIrq(centerIrq)
);

// ### verification/can_node_model.sv
`timescale 1ns/100ps

module can_node_model (
    // clock
    input wire logic                     clock,
    // frames toward the block
    output logic                         rxValid,
    output can_msg_pkg::can_frame_t      rxFrame,
    // reply words from the block
    input wire logic                     txValid,
    input wire logic [15:0]              txWord,
    output logic                         txReady,
    // stall request from the bench
    input wire logic                     stall
);
    logic [15:0] got[$];
    logic [7:0]  rnd = 8'hA5;

    initial begin
        rxValid = 1'b0;
        rxFrame = '0;
        txReady = 1'b0;
    end

    // a word counts only where valid and ready meet at one edge
    always @(posedge clock) begin
        if (txValid && txReady) got.push_back(txWord);
        rnd <= {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        txReady <= !stall && rnd[0];
    end

    task automatic send(input can_msg_pkg::can_frame_t f);
        rxValid <= 1'b1;
        rxFrame <= f;
        @(posedge clock);
        rxValid <= 1'b0;
        // released: never leave the old frame on the lines
        rxFrame <= ~f;
    endtask
endmodule

// ### verification/test_can_message_center.sv
`timescale 1ns/100ps
`include "can_msg_defs.svh"

module test_can_message_center;
    logic                    clock;
    logic                    rst;
    can_msg_pkg::reg_req_t   regReq;
    logic [15:0]             rdData;
    logic                    rxValid;
    can_msg_pkg::can_frame_t rxFrame;
    logic                    rxBusy;
    logic                    txValid;
    logic [15:0]             txWord;
    logic                    txReady;
    logic [7:0]              errorInfo;
    logic                    busOff;
    logic                    centerIrq;
    logic                    stall;
    logic                    enabled;
    int                      badCount;
    int                      nTests;
    int                      cycles;
    logic [31:0]             seed = 32'h2836;
    logic [28:0]             cid[16];
    logic [15:0]             cc[16];
    logic [63:0]             mdat[16];
    logic [15:0]             expq[$];
    logic [15:0]             media;
    logic [28:0]             gmask;
    logic [15:0]             v;
    can_msg_pkg::can_frame_t f;

    can_message_center dut_u (
        .clock(clock), .rst(rst), .regReq(regReq), .rdData(rdData), .rxValid(rxValid), .rxFrame(rxFrame),
        .rxBusy(rxBusy), .txValid(txValid), .txWord(txWord), .txReady(txReady), .errorInfo(errorInfo),
        .busOff(busOff), .bitTiming(), .canEnable(), .centerIrq(centerIrq)
    );
    can_node_model node_u (
        .clock(clock), .rxValid(rxValid), .rxFrame(rxFrame), .txValid(txValid), .txWord(txWord),
        .txReady(txReady), .stall(stall)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            close_out();
        end
    end

    // ----------------------------------------
    // reference model and bus tasks
    // ----------------------------------------
    function automatic logic [15:0] rnd16();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction

    function automatic can_msg_pkg::can_frame_t mkf(input logic e, r, input logic [28:0] id, input logic [3:0] n);
        mkf = '{e, r, id, n, {media, rnd16(), rnd16(), rnd16()}};
    endfunction

    // first center that matches wins; unmatched remote frames are dropped
    function automatic int pick(input can_msg_pkg::can_frame_t g);
        logic [28:0] m;
        for (int c = 1; c < 15; c++) begin
            m = cc[c][7] ? ~gmask : 29'h1FFFFFFF;
            if (!cc[c][6]) m[28:11] = '0;
            if (cc[c][6] == g.ext && ((cid[c] ^ g.id) & m) == 0 && (g.rtr ? (cc[c][8] && cc[c][4:0] == 5'h1D)
                : (g.data[63:48] == media && !cc[c][0] && cc[c][3]))) return c;
        end
        return g.rtr ? 0 : 15;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        nTests++;
        if (seen !== want) begin
            badCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        regReq.addr <= a;
        regReq.wdata <= d;
        regReq.wr <= 1'b1;
        @(posedge clock);
        regReq.wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [15:0] want);
        regReq.addr <= a;
        regReq.rd <= 1'b1;
        @(posedge clock);
        regReq.rd <= 1'b0;
        #1 v = rdData;
        chk(v, want);
        @(posedge clock);
    endtask

    task automatic mw(input int a, input logic [15:0] d);
        wr(`ADDR_DP_PTR, 16'(a));
        wr(`ADDR_DP_BUF, d);
    endtask

    task automatic reply(input int k);
        expq.push_back({cc[k][6], 2'b00, cid[k][28:16]});
        expq.push_back(cid[k][15:0]);
        expq.push_back({12'h000, cc[k][12:9]});
        for (int w = 0; w < 4; w++) expq.push_back(mdat[k][63 - 16 * w -: 16]);
    endtask

    task automatic flush();
        for (int i = 0; i < 3000 && (node_u.got.size() < expq.size() || txValid); i++) @(posedge clock);
        chk(16'(node_u.got.size()), 16'(expq.size()));
        while (expq.size() > 0 && node_u.got.size() > 0) chk(node_u.got.pop_front(), expq.pop_front());
        node_u.got.delete();
        expq.delete();
    endtask

    task automatic rx(input can_msg_pkg::can_frame_t g);
        int k;
        int i;
        k = enabled ? pick(g) : 0;
        node_u.send(g);
        #1 i = 0;
        while (rxBusy !== 1'b0 && i < 2000) begin
            @(posedge clock);
            #1 i++;
        end
        if (k > 0 && g.rtr) reply(k);
        if (k > 0 && !g.rtr) begin
            mdat[k] = g.data;
            cc[k][2] = 1'b1;
            cc[k][12:9] = g.dlc;
            rdc(`ADDR_SRC, 16'(k));
            #1 chk({15'h0, centerIrq}, {15'h0, cc[k][5]});
            rdc(`ADDR_NEWDAT, 16'h0001 << k);
            wr(`ADDR_NEWDAT, 16'hFFFF);
            for (int w = 0; w < 4; w++) begin
                wr(`ADDR_DP_PTR, 16'(k * 8 + 2 + w));
                rdc(`ADDR_DP_BUF, g.data[63 - 16 * w -: 16]);
            end
            if (k < 15) rdc(`ADDR_CCTL0 + 6'(k), cc[k]);
        end
        @(posedge clock);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        regReq = '0;
        errorInfo = 8'h00;
        busOff = 1'b0;
        stall = 1'b0;
        enabled = 1'b0;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rdc(`ADDR_GCTRL, 16'h0000);
        rdc(`ADDR_BTIME, `RST_BTIME);
        rdc(`ADDR_CCTL0 + 6'h3, `RST_CCTL);
        rdc(6'h0A, 16'h0000);
        f.data[15:0] = rnd16();
        wr(`ADDR_BTIME, f.data[15:0]);
        rdc(`ADDR_BTIME, f.data[15:0]);
        gmask = '0;
        for (int c = 0; c < 3; c++) mw(c, 16'h0000);
        for (int c = 1; c < 16; c++) begin
            cid[c] = 29'h100 + 29'(c);
            cc[c] = 16'h0008;
            wr(`ADDR_CCTL0 + 6'(c), cc[c]);
            mw(c * 8, 16'h0000);
            mw(c * 8 + 1, cid[c][15:0]);
        end
        f.data[15:0] = rnd16();
        media = {f.data[7:0], f.data[7:0]};
        wr(`ADDR_MA_LO, {8'h00, media[7:0]});
        wr(`ADDR_MA_HI, {8'h00, media[7:0]});
        rx(mkf(0, 0, 29'h103, 4'h8));
        rdc(`ADDR_NEWDAT, 16'h0000);
        wr(`ADDR_GCTRL, 16'h0001);
        enabled = 1'b1;
        cc[3][5] = 1'b1;
        wr(`ADDR_CCTL0 + 6'h3, cc[3]);
        rx(mkf(0, 0, 29'h103, 4'h8));
        f = mkf(0, 0, 29'h104, 4'h2);
        f.data[63:56] = ~f.data[63:56];
        rx(f);
        rx(mkf(0, 0, 29'h1FF, 4'h0));
        gmask = 29'h0000000F;
        mw(1, 16'h000F);
        cc[5][7] = 1'b1;
        wr(`ADDR_CCTL0 + 6'h5, cc[5]);
        rx(mkf(0, 0, 29'h10C, 4'h4));
        cc[5][7] = 1'b0;
        wr(`ADDR_CCTL0 + 6'h5, cc[5]);
        rx(mkf(0, 0, 29'h10C, 4'h4));
        cid[7] = 29'h1ABC0107;
        cc[7][6] = 1'b1;
        mw(56, {3'h0, cid[7][28:16]});
        mw(57, cid[7][15:0]);
        wr(`ADDR_CCTL0 + 6'h7, cc[7]);
        rx(mkf(1, 0, cid[7], 4'h8));
        rx(mkf(0, 0, 29'h107, 4'h1));
        mdat[2] = {rnd16(), rnd16(), rnd16(), rnd16()};
        for (int w = 0; w < 4; w++) mw(18 + w, mdat[2][63 - 16 * w -: 16]);
        // bit 5 is interrupt enable, so the last pass leaves the center armed
        for (int b = 0; b < 6; b++) begin
            cc[2] = 16'h0D1D ^ (16'h0001 << b);
            wr(`ADDR_CCTL0 + 6'h2, cc[2]);
            rx(mkf(0, 1, 29'h102, 4'h0));
            flush();
        end
        stall <= 1'b1;
        repeat (4) rx(mkf(0, 1, 29'h102, 4'h0));
        node_u.send(mkf(0, 1, 29'h102, 4'h0));
        reply(2);
        repeat (20) @(posedge clock);
        #1 chk({15'h0, rxBusy}, 16'h0001);
        node_u.send(mkf(0, 0, 29'h103, 4'h8));
        f.data[15:0] = rnd16();
        errorInfo <= f.data[7:0];
        busOff <= 1'b1;
        stall <= 1'b0;
        rx(mkf(0, 1, 29'h1F0, 4'h0));
        flush();
        rdc(`ADDR_GSTAT, {8'h81, f.data[7:0]});
        wr(`ADDR_GSTAT, 16'h8000);
        rdc(`ADDR_GSTAT, {8'h01, f.data[7:0]});
        close_out();
    end
endmodule
